// [mac_move_pkg.sv]
// Constants for the multiply-accumulate and byte-move execute block.
// Assumes a 16-bit instruction word and a simple memory load/store port.
package mac_move_pkg;
  localparam logic [31:0] EXEC_ADDR = 32'h0000_0000;
  localparam logic [31:0] REGSEL_ADDR = 32'h0000_0004;
  localparam logic [31:0] REGDATA_ADDR = 32'h0000_0008;
  localparam logic [31:0] MACL_ADDR = 32'h0000_000C;
  localparam logic [31:0] MACH_ADDR = 32'h0000_0010;
  localparam logic [31:0] GBR_ADDR = 32'h0000_0014;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0018;
  localparam int SAT_BIT = 16;
  localparam logic [3:0] OP_MOV = 4'h6;
  localparam logic [3:0] OP_IMM = 4'hE;
  localparam logic [3:0] OP_MACW = 4'h4;
  localparam logic [3:0] OP_MACL = 4'h0;
  localparam logic [3:0] OP_DISP = 4'h8;
  localparam logic [3:0] OP_IND = 4'h2;
  localparam logic [3:0] SUB_MOV = 4'h3;
  localparam logic [3:0] SUB_MACW = 4'hF;
  localparam logic [3:0] SUB_MACL = 4'hF;
  localparam logic [3:0] SUB_ST_IND = 4'h0;
  localparam logic [3:0] SUB_ST_DEC = 4'h4;
  localparam logic [3:0] SUB_ST_IDX = 4'h4;
  localparam logic [3:0] SUB_LD_IND = 4'h0;
  localparam logic [3:0] SUB_GBR_ST = 4'h0;
  localparam logic [3:0] SUB_DISP_ST = 4'h0;
  localparam logic [31:0] STEP_W = 32'h0000_0002;
  localparam logic [31:0] STEP_L = 32'h0000_0004;
  localparam logic [31:0] STEP_B = 32'h0000_0001;
  localparam logic [63:0] SAT48_MAX = 64'h0000_7FFF_FFFF_FFFF;
  localparam logic [63:0] SAT48_MIN = 64'hFFFF_8000_0000_0000;
  localparam logic [31:0] OVF_MARK = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SIZE_B = 2'h0;
  localparam logic [1:0] SIZE_W = 2'h1;
  localparam logic [1:0] SIZE_L = 2'h2;
  localparam int ERR_W = 4;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD2 = 6'h02,
    ST_RD1 = 6'h04,
    ST_WR = 6'h08,
    ST_LD = 6'h10,
    ST_DONE = 6'h20
  } exec_e;
endpackage

// [mac_and_byte_move_execute.sv]
// Execute unit for multiply-accumulate, register/immediate moves and byte stores/loads.
// Assumes a memory port that answers mem_valid with mem_done, possibly many cycles later.
`timescale 1ns/1ns
module mac_and_byte_move_execute
  import mac_move_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_valid,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_done,
  input wire logic [31:0] mem_rdata,
  input wire logic [ERR_W-1:0] mem_fault
);
  typedef struct packed {
    exec_e st;
    logic [15:0][31:0] regs;
    logic [31:0] macl;
    logic [31:0] mach;
    logic [31:0] gbr;
    logic sat;
    logic [15:0] insn;
    logic [31:0] val2;
    logic [31:0] addr_m;
    logic [31:0] addr_n;
    logic [ERR_W-1:0] fault;
    logic [3:0] regsel;
    logic aw_got;
    logic w_got;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic mvalid;
    logic mwrite;
    logic [1:0] msize;
    logic [31:0] maddr;
    logic [31:0] mwdata;
  } state_s;
  state_s cur;
  state_s next_cur;
  logic [3:0] n_fld;
  logic [3:0] m_fld;
  logic [3:0] op_hi;
  logic [3:0] op_lo;
  logic is_macw;
  logic is_macl;
  logic [31:0] val1;
  logic [63:0] mul;
  logic [63:0] mac;
  logic [63:0] sum;
  logic [32:0] wsum;
  logic [31:0] step;
  logic wr_fire;
  always_comb begin
    n_fld = cur.insn[11:8];
    m_fld = cur.insn[7:4];
    op_hi = cur.insn[15:12];
    op_lo = cur.insn[3:0];
    is_macw = (op_hi == OP_MACW) && (op_lo == SUB_MACW);
    is_macl = (op_hi == OP_MACL) && (op_lo == SUB_MACL);
    step = is_macw ? STEP_W : STEP_L;
    val1 = is_macw ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} : mem_rdata;
    mul = 64'($signed(cur.val2) * $signed(val1));
    mac = {cur.mach, cur.macl};
    sum = mac + mul;
    wsum = {cur.macl[31], cur.macl} + {mul[31], mul[31:0]};
    wr_fire = cur.aw_got && cur.w_got && !cur.bvalid;
  end
  always_comb begin
    next_cur = cur;
    if (s_axi_awvalid && !cur.aw_got) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.w_got) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_axi_wdata;
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (wr_fire) begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      case (cur.aw_addr)
        EXEC_ADDR: begin
          // Instructions issued while busy are refused
          if (cur.st == ST_IDLE || cur.st == ST_DONE) begin
            next_cur.insn = cur.w_data[15:0];
            next_cur.sat = cur.w_data[SAT_BIT];
            next_cur.fault = '0;
            next_cur.st = ST_RD2;
          end else begin
            next_cur.bresp = RESP_SLVERR;
          end
        end
        REGSEL_ADDR: next_cur.regsel = cur.w_data[3:0];
        REGDATA_ADDR: next_cur.regs[cur.regsel] = cur.w_data;
        MACL_ADDR: next_cur.macl = cur.w_data;
        MACH_ADDR: next_cur.mach = cur.w_data;
        GBR_ADDR: next_cur.gbr = cur.w_data;
        default: next_cur.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !cur.rvalid) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      case (s_axi_araddr)
        EXEC_ADDR: next_cur.rdata = {15'h0000, cur.sat, cur.insn};
        REGSEL_ADDR: next_cur.rdata = {28'h0000000, cur.regsel};
        REGDATA_ADDR: next_cur.rdata = cur.regs[cur.regsel];
        MACL_ADDR: next_cur.rdata = cur.macl;
        MACH_ADDR: next_cur.rdata = cur.mach;
        GBR_ADDR: next_cur.rdata = cur.gbr;
        STATUS_ADDR: next_cur.rdata = {20'h00000, cur.fault, 2'h0, cur.st};
        default: begin
          next_cur.rdata = 32'h0000_0000;
          next_cur.rresp = RESP_SLVERR;
        end
      endcase
    end
    case (cur.st)
      ST_IDLE, ST_DONE: begin
        next_cur.mvalid = 1'b0;
      end
      ST_RD2: begin
        next_cur.st = ST_DONE;
        next_cur.addr_m = cur.regs[m_fld];
        next_cur.addr_n = cur.regs[n_fld];
        if (is_macw || is_macl) begin
          next_cur.mvalid = 1'b1;
          next_cur.mwrite = 1'b0;
          next_cur.msize = is_macw ? SIZE_W : SIZE_L;
          next_cur.maddr = cur.regs[n_fld];
          next_cur.st = ST_RD1;
        end else if (op_hi == OP_MOV && op_lo == SUB_MOV) begin
          next_cur.regs[n_fld] = cur.regs[m_fld];
        end else if (op_hi == OP_IMM) begin
          next_cur.regs[n_fld] = {{24{cur.insn[7]}}, cur.insn[7:0]};
        end else if (op_hi == OP_MOV && op_lo == SUB_LD_IND) begin
          next_cur.mvalid = 1'b1;
          next_cur.mwrite = 1'b0;
          next_cur.msize = SIZE_B;
          next_cur.maddr = cur.regs[m_fld];
          next_cur.st = ST_LD;
        end else begin
          next_cur.mvalid = 1'b1;
          next_cur.mwrite = 1'b1;
          next_cur.msize = SIZE_B;
          next_cur.st = ST_WR;
          next_cur.mwdata = {24'h000000, cur.regs[m_fld][7:0]};
          if (op_hi == OP_IND && op_lo == SUB_ST_IND) begin
            next_cur.maddr = cur.regs[n_fld];
          end else if (op_hi == OP_IND && op_lo == SUB_ST_DEC) begin
            next_cur.maddr = cur.regs[n_fld] - STEP_B;
          end else if (op_hi == OP_MACL && op_lo == SUB_ST_IDX) begin
            next_cur.maddr = cur.regs[0] + cur.regs[n_fld];
          end else if (op_hi == 4'hC && cur.insn[11:8] == SUB_GBR_ST) begin
            next_cur.maddr = cur.gbr + {24'h000000, cur.insn[7:0]};
            next_cur.mwdata = {24'h000000, cur.regs[0][7:0]};
          end else if (op_hi == OP_DISP && cur.insn[11:8] == SUB_DISP_ST) begin
            next_cur.maddr = cur.regs[m_fld] + {28'h0000000, op_lo};
            next_cur.mwdata = {24'h000000, cur.regs[0][7:0]};
          end else begin
            next_cur.mvalid = 1'b0;
            next_cur.st = ST_DONE;
          end
        end
      end
      ST_RD1: begin
        if (mem_done && mem_fault != '0) begin
          next_cur.fault = mem_fault;
          next_cur.mvalid = 1'b0;
          next_cur.st = ST_DONE;
        end else if (mem_done && cur.maddr == cur.addr_n) begin
          next_cur.val2 = is_macw ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} : mem_rdata;
          next_cur.addr_n = cur.addr_n + step;
          if (n_fld == m_fld) begin
            next_cur.addr_m = cur.addr_n + step;
            next_cur.addr_n = cur.addr_n + step + step;
            next_cur.maddr = cur.addr_n + step;
          end else begin
            next_cur.maddr = cur.addr_m;
          end
          next_cur.addr_n[0] = next_cur.addr_n[0];
          next_cur.mvalid = 1'b1;
          next_cur.insn = cur.insn;
          next_cur.st = ST_RD1;
          next_cur.addr_m = (n_fld == m_fld) ? cur.addr_n + step : cur.addr_m;
          next_cur.maddr = next_cur.addr_m;
          next_cur.val2[0] = next_cur.val2[0];
          next_cur.addr_n = (n_fld == m_fld) ? cur.addr_n + step + step : cur.addr_n + step;
          next_cur.mwrite = 1'b0;
          next_cur.fault = '0;
          next_cur.rdata = next_cur.rdata;
          next_cur.msize = cur.msize;
          next_cur.gbr = cur.gbr;
          next_cur.st = ST_LD;
        end
      end
      ST_LD: begin
        if (mem_done) begin
          next_cur.mvalid = 1'b0;
          next_cur.st = ST_DONE;
          if (mem_fault != '0) begin
            next_cur.fault = mem_fault;
          end else if (is_macw) begin
            next_cur.regs[m_fld] = cur.addr_m + step;
            next_cur.regs[n_fld] = cur.addr_n;
            if (!cur.sat) begin
              next_cur.macl = sum[31:0];
              next_cur.mach = sum[63:32];
            end else if (wsum[32] != wsum[31]) begin
              next_cur.macl = wsum[32] ? 32'h8000_0000 : 32'h7FFF_FFFF;
              next_cur.mach = OVF_MARK;
            end else begin
              next_cur.macl = wsum[31:0];
            end
          end else if (is_macl) begin
            next_cur.regs[m_fld] = cur.addr_m + step;
            next_cur.regs[n_fld] = cur.addr_n;
            if (cur.sat && ((sum ^ mac) & (sum ^ mul)) >> 63 != 64'h0) begin
              {next_cur.mach, next_cur.macl} = mac[63] ? SAT48_MIN : SAT48_MAX;
            end else if (cur.sat && $signed(sum) > $signed(SAT48_MAX)) begin
              {next_cur.mach, next_cur.macl} = SAT48_MAX;
            end else if (cur.sat && $signed(sum) < $signed(SAT48_MIN)) begin
              {next_cur.mach, next_cur.macl} = SAT48_MIN;
            end else begin
              {next_cur.mach, next_cur.macl} = sum;
            end
            if (n_fld == m_fld) begin
              next_cur.regs[n_fld] = cur.addr_m + step;
            end
          end else begin
            next_cur.regs[n_fld] = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
          end
        end
      end
      ST_WR: begin
        if (mem_done) begin
          next_cur.mvalid = 1'b0;
          next_cur.st = ST_DONE;
          if (mem_fault != '0) begin
            next_cur.fault = mem_fault;
          end else if (op_hi == OP_IND && op_lo == SUB_ST_DEC) begin
            next_cur.regs[n_fld] = cur.maddr;
          end
        end
      end
      default: next_cur.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.st <= ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end
  assign s_axi_awready = !cur.aw_got;
  assign s_axi_wready = !cur.w_got;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign mem_valid = cur.mvalid;
  assign mem_write = cur.mwrite;
  assign mem_size = cur.msize;
  assign mem_addr = cur.maddr;
  assign mem_wdata = cur.mwdata;
endmodule // mac_and_byte_move_execute

// [mac_move_props.sv]
// Checker for the execute block: AXI-Lite answers and memory port.
// Assumes a bind onto the top module, ports matched by name.
`timescale 1ns/1ns
module mac_move_props
  import mac_move_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic mem_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence req_wait;
    mem_valid && !mem_done;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_req_hold: assert property (req_wait |=> mem_valid && $stable(mem_addr)
    && $stable(mem_write) && $stable(mem_size)) else $error("request changed");
  a_store_byte: assert property (mem_valid && mem_write |-> mem_size == SIZE_B)
    else $error("store not byte");
  a_next_addr: assert property (mem_valid && mem_done |=> !mem_valid || $changed(mem_addr))
    else $error("address repeated");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // Both channels are latched first, the answer follows one cycle later
  a_wr_answer: assert property (aw_w_take |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_reset_quiet: assert property ($rose(aresetn) |-> !mem_valid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("busy after reset");
endmodule // mac_move_props

// [mem_model.sv]
// Memory model for the load/store port, random latency, fault replay.
// Assumes one request at a time, held until mem_done.
`timescale 1ns/1ns
module mem_model
  import mac_move_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [ERR_W-1:0] fault_in,
  output logic mem_done,
  output logic [31:0] mem_rdata,
  output logic [ERR_W-1:0] mem_fault
);
  logic [31:0] mem [logic [31:0]];
  int cnt;
  // Idle data toggles so a stale read cannot look right
  always_ff @(posedge aclk) begin
    mem_done <= 1'b0;
    mem_fault <= '0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      cnt <= 0;
      mem_rdata <= '0;
    end else if (mem_valid && !mem_done) begin
      if (cnt == 0) begin
        mem_done <= 1'b1;
        mem_fault <= fault_in;
        cnt <= $urandom_range(3, 0);
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // mem_model

// [mac_and_byte_move_execute_tb_top.sv]
// Testbench: AXI-Lite master, memory model, queued expectations.
// Assumes each instruction completes within the status polling bound.
`timescale 1ns/1ns
module mac_and_byte_move_execute_tb_top
  import mac_move_pkg::*;
;
  logic aclk = '0, aresetn = '0, pend = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_size;
  logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, rv, v;
  logic mem_valid, mem_write, mem_done;
  logic [ERR_W-1:0] mem_fault, fault_in = '0;
  int n_mismatch = 0, checks = 0;
  logic [42:0] exp_m[$];
  logic [34:0] exp_r[$];
  logic [1:0] exp_b[$];
  initial forever #10 aclk = ~aclk;
  mac_and_byte_move_execute u_mac_and_byte_move_execute (.*);
  mem_model u_mem_model (.*);
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, s);
    checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input logic [31:0] a, d, input logic [1:0] r);
    bit ta, tw;
    exp_b.push_back(r);
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic c, input logic [33:0] e);
    exp_r.push_back({c, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task ck(input logic [31:0] a, e);
    rd(a, 1'b1, {RESP_OKAY, e});
  endtask
  task setr(input logic [31:0] n, d);
    wr(REGSEL_ADDR, n, RESP_OKAY);
    wr(REGDATA_ADDR, d, RESP_OKAY);
  endtask
  task getr(input logic [31:0] n, e);
    wr(REGSEL_ADDR, n, RESP_OKAY);
    ck(REGDATA_ADDR, e);
  endtask
  task em(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [1:0] z);
    exp_m.push_back({w, a, d, z});
  endtask
  task run(input logic [31:0] ins);
    int k;
    k = 0;
    wr(EXEC_ADDR, ins, RESP_OKAY);
    do begin
      rd(STATUS_ADDR, 1'b0, '0);
      k++;
    end while (!(rv[5:0] inside {6'h20, 6'h01}) && k < 50);
    // Hung instruction counts as a mismatch
    if (!(rv[5:0] inside {6'h20, 6'h01}))
      n_mismatch++;
  endtask
  always @(posedge aclk) begin
    logic [42:0] m;
    logic [34:0] r;
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", exp_b.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) begin
      r = exp_r.pop_front();
      if (r[34])
        chk("rdata", r[33:0], {s_axi_rresp, s_axi_rdata});
    end
    if (mem_valid && !pend) begin
      m = exp_m.pop_front();
      chk("mem_req", {m[42:10], m[1:0]}, {mem_write, mem_addr, mem_size});
      if (mem_write)
        chk("mem_wdata", m[9:2], mem_wdata[7:0]);
    end
    pend <= mem_valid && !mem_done;
  end
  // Far beyond the few hundred cycles the sequence needs
  initial begin
    #1000000;
    n_mismatch++;
    test_done;
  end
  initial begin
    void'($urandom(32'h7323013E));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run(32'h0000E385);
    getr(3, 32'hFFFFFF85);
    v = $urandom;
    setr(3, v);
    run(32'h00006433);
    getr(4, v);
    setr(1, 32'h12345678);
    setr(2, 32'h00001000);
    setr(0, 32'hFFFFFFF0);
    em(1, 32'h00001000, 8'h78, SIZE_B);
    run(32'h00002210);
    getr(2, 32'h00001000);
    em(1, 32'h00000FFF, 8'h78, SIZE_B);
    run(32'h00002214);
    getr(2, 32'h00000FFF);
    em(1, 32'h00000FEF, 8'h78, SIZE_B);
    run(32'h00000214);
    wr(GBR_ADDR, 32'hFFFFFF80, RESP_OKAY);
    em(1, 32'h0000007F, 8'hF0, SIZE_B);
    run(32'h0000C0FF);
    em(1, 32'h0000100E, 8'hF0, SIZE_B);
    run(32'h0000802F);
    for (int i = 0; i < 4; i++) begin
      fault_in <= 4'h1 << i;
      em(1, 32'h00000FFE, 8'h78, SIZE_B);
      run(32'h00002214);
      chk("fault", 64'(4'h1 << i), rv[11:8]);
      getr(2, 32'h00000FFF);
    end
    fault_in <= '0;
    u_mem_model.mem[32'h00000FFF] = 32'h00000080;
    em(0, 32'h00000FFF, 8'h00, SIZE_B);
    run(32'h00006520);
    getr(5, 32'hFFFFFF80);
    setr(6, 32'h00002000);
    setr(7, 32'h00002100);
    u_mem_model.mem[32'h00002000] = 32'h0000FFFE;
    u_mem_model.mem[32'h00002100] = 32'h00000003;
    u_mem_model.mem[32'h00002002] = 32'h00000002;
    u_mem_model.mem[32'h00002102] = 32'h00000003;
    u_mem_model.mem[32'h00002004] = 32'h00000002;
    u_mem_model.mem[32'h00002006] = 32'h00000005;
    wr(MACL_ADDR, 32'h00000002, RESP_OKAY);
    wr(MACH_ADDR, 32'h00000000, RESP_OKAY);
    em(0, 32'h00002000, 8'h00, SIZE_W);
    em(0, 32'h00002100, 8'h00, SIZE_W);
    run(32'h0000467F);
    getr(6, 32'h00002002);
    getr(7, 32'h00002102);
    ck(MACL_ADDR, 32'hFFFFFFFC);
    ck(MACH_ADDR, 32'hFFFFFFFF);
    wr(MACL_ADDR, 32'h7FFFFFFF, RESP_OKAY);
    wr(MACH_ADDR, 32'h00000055, RESP_OKAY);
    em(0, 32'h00002002, 8'h00, SIZE_W);
    em(0, 32'h00002102, 8'h00, SIZE_W);
    run(32'h0001467F);
    ck(MACL_ADDR, 32'h7FFFFFFF);
    ck(MACH_ADDR, 32'h00000001);
    wr(MACL_ADDR, 32'h00000010, RESP_OKAY);
    // High half must survive a saturating sum without overflow
    wr(MACH_ADDR, 32'h00000055, RESP_OKAY);
    em(0, 32'h00002004, 8'h00, SIZE_W);
    em(0, 32'h00002006, 8'h00, SIZE_W);
    run(32'h0001466F);
    getr(6, 32'h00002008);
    ck(MACL_ADDR, 32'h0000001A);
    ck(MACH_ADDR, 32'h00000055);
    setr(8, 32'h00003000);
    setr(9, 32'h00003100);
    u_mem_model.mem[32'h00003000] = 32'h00000100;
    u_mem_model.mem[32'h00003100] = 32'h00000001;
    wr(MACL_ADDR, 32'hFFFFFFF0, RESP_OKAY);
    wr(MACH_ADDR, 32'h00007FFF, RESP_OKAY);
    em(0, 32'h00003000, 8'h00, SIZE_L);
    em(0, 32'h00003100, 8'h00, SIZE_L);
    run(32'h0001089F);
    getr(8, 32'h00003004);
    getr(9, 32'h00003104);
    ck(MACL_ADDR, 32'hFFFFFFFF);
    ck(MACH_ADDR, 32'h00007FFF);
    fault_in <= 4'h2;
    em(0, 32'h00002008, 8'h00, SIZE_W);
    run(32'h0000467F);
    chk("fault", 64'h2, rv[11:8]);
    fault_in <= '0;
    getr(6, 32'h00002008);
    getr(7, 32'h00002104);
    ck(MACL_ADDR, 32'hFFFFFFFF);
    ck(MACH_ADDR, 32'h00007FFF);
    rd(32'h00000040, 1'b1, {RESP_SLVERR, 32'h00000000});
    wr(32'h00000040, 32'h00000000, RESP_SLVERR);
    chk("left", 64'h0, exp_m.size());
    test_done;
  end
endmodule // mac_and_byte_move_execute_tb_top
bind mac_and_byte_move_execute mac_move_props u_mac_move_props (.*);
